// ===== logic/pxb_pkg.sv
// Constants for the port crossbar and general-purpose pin block.
package pxb_pkg;
  localparam logic [7:0] ADDR_PORT = 8'h80;
  localparam logic [7:0] ADDR_ROUTE = 8'hE2;
  localparam logic [7:0] ADDR_IN_MODE = 8'hF1;
  localparam logic [7:0] ADDR_GLOBAL = 8'hF3;
  localparam logic [7:0] ADDR_OUT_MODE = 8'hA4;
  localparam logic [7:0] ADDR_SKIP = 8'hE1;
  localparam logic [7:0] RST_PORT = 8'hFF;
  localparam logic [7:0] RST_ROUTE = 8'h00;
  localparam logic [7:0] RST_IN_MODE = 8'hFF;
  localparam logic [7:0] RST_GLOBAL = 8'h00;
  localparam logic [7:0] RST_OUT_MODE = 8'h00;
  localparam logic [7:0] RST_SKIP = 8'h00;
  localparam logic [7:0] GLOBAL_WMASK = 8'hC7;
  localparam logic [7:0] SKIP_WMASK = 8'h7F;
  localparam int ROUTE_CEX_LO = 6;
  localparam int ROUTE_CPA = 5;
  localparam int ROUTE_CPS = 4;
  localparam int ROUTE_CLK = 3;
  localparam int ROUTE_SMB = 2;
  localparam int ROUTE_RX = 1;
  localparam int ROUTE_TX = 0;
  localparam int GLB_PUD = 7;
  localparam int GLB_XBAR = 6;
  localparam int GLB_T1 = 2;
  localparam int GLB_T0 = 1;
  localparam int GLB_ECI = 0;
  localparam int PIN_TX = 4;
  localparam int PIN_RX = 5;
  typedef logic [3:0] pxb_fn_t;
  localparam pxb_fn_t FN_GPIO = 4'h0;
  localparam pxb_fn_t FN_TX = 4'h1;
  localparam pxb_fn_t FN_RX = 4'h2;
  localparam pxb_fn_t FN_SDA = 4'h3;
  localparam pxb_fn_t FN_SCL = 4'h4;
  localparam pxb_fn_t FN_CPS = 4'h5;
  localparam pxb_fn_t FN_CPA = 4'h6;
  localparam pxb_fn_t FN_CLK = 4'h7;
  localparam pxb_fn_t FN_CAPCOMP_MODULE_OUT_0 = 4'h8;
  localparam pxb_fn_t FN_CEX1 = 4'h9;
  localparam pxb_fn_t FN_CEX2 = 4'hA;
  localparam pxb_fn_t FN_ECI = 4'hB;
  localparam pxb_fn_t FN_T0 = 4'hC;
  localparam pxb_fn_t FN_T1 = 4'hD;
  localparam int FN_FIRST = 3;
  localparam int FN_LAST = 13;
endpackage : pxb_pkg

// ===== logic/pxb_port_crossbar.sv
// Port crossbar, port latch and pin mode logic for an eight-pin port.
`timescale 1ns/10ps
`default_nettype none
module pxb_port_crossbar (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic SFR_WR,
  input wire logic SFR_RD_RMW,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  input wire logic [7:0] PIN_IN,
  output logic [7:0] PIN_OUT,
  output logic [7:0] PIN_OE_B,
  output logic [7:0] PIN_PULLUP_EN,
  input wire logic [2:0] CEX_OUT,
  input wire logic CMP_SYNC_OUT,
  input wire logic CMP_ASYNC_OUT,
  input wire logic SDA_OUT,
  input wire logic SCL_OUT,
  input wire logic UART_TX,
  output logic SDA_IN,
  output logic SCL_IN,
  output logic UART_RX,
  output logic T0_IN,
  output logic T1_IN,
  output logic ECI_IN
);
  logic [7:0] port_data_latch;
  logic [7:0] peripheral_route_enables;
  logic [7:0] pin_input_mode;
  logic [7:0] route_global_control;
  logic [7:0] pin_output_mode;
  logic [7:0] pin_skip_bits;
  logic [7:0] pin_meta;
  logic [7:0] pin_sync;
  logic [7:0] out_q;
  logic [7:0] oe_b_q;
  logic [7:0] pu_q;
  logic [7:0] pp_q;
  pxb_pkg::pxb_fn_t code_q [8];
  pxb_pkg::pxb_fn_t code [8];
  logic [7:0] next_out;
  logic [7:0] next_oe_b;
  logic [7:0] next_pu;
  logic [7:0] next_pp;
  logic [15:0] fn_en;
  logic [7:0] taken;
  logic done;

  wire xbar_on = route_global_control[pxb_pkg::GLB_XBAR];
  wire pud = route_global_control[pxb_pkg::GLB_PUD];
  wire [1:0] cex_sel = peripheral_route_enables[7:pxb_pkg::ROUTE_CEX_LO];
  wire wr_port = SFR_WR && (SFR_ADDR == pxb_pkg::ADDR_PORT);
  wire wr_route = SFR_WR && (SFR_ADDR == pxb_pkg::ADDR_ROUTE);
  wire wr_in = SFR_WR && (SFR_ADDR == pxb_pkg::ADDR_IN_MODE);
  wire wr_glb = SFR_WR && (SFR_ADDR == pxb_pkg::ADDR_GLOBAL);
  wire wr_out = SFR_WR && (SFR_ADDR == pxb_pkg::ADDR_OUT_MODE);
  wire wr_skip = SFR_WR && (SFR_ADDR == pxb_pkg::ADDR_SKIP);
  wire [7:0] port_view = (pin_sync & pin_input_mode) | ~pin_input_mode;
  wire [7:0] port_rd = SFR_RD_RMW ? port_data_latch : port_view;

  // Flags per function code; the list order is the crossbar priority.
  always_comb begin
    fn_en = 16'h0000;
    fn_en[pxb_pkg::FN_SDA] = peripheral_route_enables[pxb_pkg::ROUTE_SMB];
    fn_en[pxb_pkg::FN_SCL] = peripheral_route_enables[pxb_pkg::ROUTE_SMB];
    fn_en[pxb_pkg::FN_CPS] = peripheral_route_enables[pxb_pkg::ROUTE_CPS];
    fn_en[pxb_pkg::FN_CPA] = peripheral_route_enables[pxb_pkg::ROUTE_CPA];
    fn_en[pxb_pkg::FN_CLK] = peripheral_route_enables[pxb_pkg::ROUTE_CLK];
    fn_en[pxb_pkg::FN_CAPCOMP_MODULE_OUT_0] = (cex_sel != 2'h0);
    fn_en[pxb_pkg::FN_CEX1] = cex_sel[1];
    fn_en[pxb_pkg::FN_CEX2] = (cex_sel == 2'h3);
    fn_en[pxb_pkg::FN_ECI] = route_global_control[pxb_pkg::GLB_ECI];
    fn_en[pxb_pkg::FN_T0] = route_global_control[pxb_pkg::GLB_T0];
    fn_en[pxb_pkg::FN_T1] = route_global_control[pxb_pkg::GLB_T1];
  end

  // Priority decoder. A function that finds no free pin is simply dropped.
  always_comb begin
    taken = pin_skip_bits;
    done = 1'b0;
    for (int i = 0; i < 8; i++) begin
      code[i] = pxb_pkg::FN_GPIO;
    end
    if (peripheral_route_enables[pxb_pkg::ROUTE_TX]) begin
      code[pxb_pkg::PIN_TX] = pxb_pkg::FN_TX;
      taken[pxb_pkg::PIN_TX] = 1'b1;
    end
    if (peripheral_route_enables[pxb_pkg::ROUTE_RX]) begin
      code[pxb_pkg::PIN_RX] = pxb_pkg::FN_RX;
      taken[pxb_pkg::PIN_RX] = 1'b1;
    end
    for (int f = pxb_pkg::FN_FIRST; f <= pxb_pkg::FN_LAST; f++) begin
      done = 1'b0;
      for (int i = 0; i < 8; i++) begin
        if (fn_en[f] && !done && !taken[i]) begin
          code[i] = 4'(f);
          taken[i] = 1'b1;
          done = 1'b1;
        end
      end
    end
    if (!xbar_on) begin
      for (int i = 0; i < 8; i++) begin
        code[i] = pxb_pkg::FN_GPIO;
      end
    end
  end

  // Per-pin drive decision, registered so unaffected pins cannot glitch.
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_pin
      logic val;
      logic smb;
      logic dig;
      always_comb begin
        case (code[g])
          pxb_pkg::FN_TX: val = UART_TX;
          pxb_pkg::FN_SDA: val = SDA_OUT;
          pxb_pkg::FN_SCL: val = SCL_OUT;
          pxb_pkg::FN_CPS: val = CMP_SYNC_OUT;
          pxb_pkg::FN_CAPCOMP_MODULE_OUT_0: val = CEX_OUT[0];
          pxb_pkg::FN_CEX1: val = CEX_OUT[1];
          pxb_pkg::FN_CEX2: val = CEX_OUT[2];
          default: val = port_data_latch[g];
        endcase
      end
      assign smb = (code[g] == pxb_pkg::FN_SDA) || (code[g] == pxb_pkg::FN_SCL);
      assign dig = pin_input_mode[g];
      assign next_pp[g] = dig && pin_output_mode[g] && !smb;
      assign next_out[g] = val;
      assign next_oe_b[g] = !(xbar_on && dig && (!val || next_pp[g]));
      assign next_pu[g] = dig && !pud && !next_pp[g] &&
                          !(xbar_on && !val);
    end
  endgenerate

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pin_meta <= 8'h00;
      pin_sync <= 8'h00;
    end else begin
      pin_meta <= PIN_IN;
      pin_sync <= pin_meta;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      port_data_latch <= pxb_pkg::RST_PORT;
      peripheral_route_enables <= pxb_pkg::RST_ROUTE;
      pin_input_mode <= pxb_pkg::RST_IN_MODE;
      route_global_control <= pxb_pkg::RST_GLOBAL;
      pin_output_mode <= pxb_pkg::RST_OUT_MODE;
      pin_skip_bits <= pxb_pkg::RST_SKIP;
    end else begin
      if (wr_port) port_data_latch <= SFR_WDATA;
      if (wr_route) peripheral_route_enables <= SFR_WDATA;
      if (wr_in) pin_input_mode <= SFR_WDATA;
      if (wr_glb) route_global_control <= SFR_WDATA & pxb_pkg::GLOBAL_WMASK;
      if (wr_out) pin_output_mode <= SFR_WDATA;
      if (wr_skip) pin_skip_bits <= SFR_WDATA & pxb_pkg::SKIP_WMASK;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      out_q <= 8'hFF;
      oe_b_q <= 8'hFF;
      pu_q <= 8'h00;
      pp_q <= 8'h00;
      for (int i = 0; i < 8; i++) code_q[i] <= pxb_pkg::FN_GPIO;
    end else begin
      out_q <= next_out;
      oe_b_q <= next_oe_b;
      pu_q <= next_pu;
      pp_q <= next_pp;
      for (int i = 0; i < 8; i++) code_q[i] <= code[i];
    end
  end

  // The inverted clock and the raw comparator cannot pass a flip-flop, so
  // those two sources bypass the output registers on their assigned pin.
  generate
    for (g = 0; g < 8; g++) begin : g_drv
      wire is_clk = (code_q[g] == pxb_pkg::FN_CLK) && pin_input_mode[g];
      wire is_cpa = (code_q[g] == pxb_pkg::FN_CPA) && pin_input_mode[g];
      wire dyn_val = is_clk ? ~CLK : CMP_ASYNC_OUT;
      wire dyn = is_clk || is_cpa;
      assign PIN_OUT[g] = dyn ? dyn_val : out_q[g];
      assign PIN_OE_B[g] = dyn ? (!pp_q[g] && dyn_val) : oe_b_q[g];
      assign PIN_PULLUP_EN[g] = pu_q[g];
    end
  endgenerate

  // Peripheral inputs idle high when no pin carries them.
  always_comb begin
    SDA_IN = 1'b1;
    SCL_IN = 1'b1;
    T0_IN = 1'b1;
    T1_IN = 1'b1;
    ECI_IN = 1'b1;
    UART_RX = 1'b1;
    for (int i = 0; i < 8; i++) begin
      if (pin_input_mode[i]) begin
        if (code_q[i] == pxb_pkg::FN_SDA) SDA_IN = pin_sync[i];
        if (code_q[i] == pxb_pkg::FN_SCL) SCL_IN = pin_sync[i];
        if (code_q[i] == pxb_pkg::FN_T0) T0_IN = pin_sync[i];
        if (code_q[i] == pxb_pkg::FN_T1) T1_IN = pin_sync[i];
        if (code_q[i] == pxb_pkg::FN_ECI) ECI_IN = pin_sync[i];
        if (code_q[i] == pxb_pkg::FN_RX) UART_RX = pin_sync[i];
      end
    end
  end

  // Read data is combinational so a read completes in its own cycle.
  always_comb begin
    case (SFR_ADDR)
      pxb_pkg::ADDR_PORT: SFR_RDATA = port_rd;
      pxb_pkg::ADDR_ROUTE: SFR_RDATA = peripheral_route_enables;
      pxb_pkg::ADDR_IN_MODE: SFR_RDATA = pin_input_mode;
      pxb_pkg::ADDR_GLOBAL: SFR_RDATA = route_global_control;
      pxb_pkg::ADDR_OUT_MODE: SFR_RDATA = pin_output_mode;
      pxb_pkg::ADDR_SKIP: SFR_RDATA = pin_skip_bits;
      default: SFR_RDATA = 8'h00;
    endcase
  end
endmodule : pxb_port_crossbar
`default_nettype wire

// ===== tb/pxb_asserts.sv
// Checker for the port crossbar, with a mirror of five of its six registers.
`timescale 1ns/10ps
`default_nettype none
module pxb_asserts (
  input wire logic CLK, RST_B, SFR_WR, SFR_RD_RMW, UART_TX,
  input wire logic [7:0] SFR_ADDR, SFR_WDATA, SFR_RDATA, PIN_IN,
  input wire logic [7:0] PIN_OUT, PIN_OE_B, PIN_PULLUP_EN,
  input wire logic SDA_IN, SCL_IN, UART_RX, T0_IN, T1_IN, ECI_IN
);
  logic [7:0] m_lat, m_in, m_rt, m_gl, m_out;
  wire tx_ok = m_rt[0] & m_gl[6] & m_in[4] & m_out[4];
  wire rx_ok = m_rt[1] & m_gl[6] & m_in[5];
  wire rd_port = SFR_ADDR == 8'h80;
  // The mirror tracks only the registers that the checks below use; the skip register is left out.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      {m_lat, m_in, m_rt, m_gl, m_out} <= 40'hFFFF000000;
    end else if (SFR_WR) begin
      if (SFR_ADDR == 8'h80) m_lat <= SFR_WDATA;
      if (SFR_ADDR == 8'hF1) m_in <= SFR_WDATA;
      if (SFR_ADDR == 8'hE2) m_rt <= SFR_WDATA;
      if (SFR_ADDR == 8'hF3) m_gl <= SFR_WDATA;
      if (SFR_ADDR == 8'hA4) m_out <= SFR_WDATA;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  a_unused_zero: assert property (
    SFR_ADDR == 8'hF3 |-> SFR_RDATA[5:3] == 3'h0)
    else $error("unused control bits read nonzero");
  a_rmw_latch: assert property (
    rd_port && SFR_RD_RMW |-> SFR_RDATA == m_lat)
    else $error("modify read differs from latch");
  a_analog_one: assert property (
    rd_port && !SFR_RD_RMW |-> (SFR_RDATA | m_in) == 8'hFF)
    else $error("analog pin read as zero");
  a_analog_quiet: assert property (
    ((~PIN_OE_B | PIN_PULLUP_EN) & ~$past(m_in)) == 8'h00)
    else $error("analog pin driven or pulled up");
  a_pullup_off: assert property (
    m_gl[7] && $past(m_gl[7]) |-> PIN_PULLUP_EN == 8'h00)
    else $error("pull-up on while disabled");
  a_xbar_off: assert property (
    !m_gl[6] && !$past(m_gl[6]) |-> PIN_OE_B == 8'hFF
    && {SDA_IN, SCL_IN, UART_RX, T0_IN, T1_IN, ECI_IN} == 6'h3F)
    else $error("pin active with crossbar off");
  a_tx_pin: assert property (
    $past(tx_ok) |-> PIN_OUT[4] == $past(UART_TX) && !PIN_OE_B[4])
    else $error("transmit not on pin four");
  a_rx_pin: assert property (
    rx_ok && $past(rx_ok) |-> UART_RX == $past(PIN_IN[5], 2))
    else $error("receive not from pin five");
endmodule : pxb_asserts
bind pxb_port_crossbar pxb_asserts u_chk (.CLK(CLK), .RST_B(RST_B),
  .SFR_WR(SFR_WR), .SFR_RD_RMW(SFR_RD_RMW), .UART_TX(UART_TX),
  .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA),
  .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE_B(PIN_OE_B),
  .PIN_PULLUP_EN(PIN_PULLUP_EN), .SDA_IN(SDA_IN), .SCL_IN(SCL_IN),
  .UART_RX(UART_RX), .T0_IN(T0_IN), .T1_IN(T1_IN), .ECI_IN(ECI_IN));
`default_nettype wire

// ===== tb/pxb_pin_model.sv
// Pads of the port with outside drivers and weak pull-ups.
`timescale 1ns/10ps
`default_nettype none
module pxb_pin_model (
  input wire logic clk,
  input wire logic [7:0] pin_out, oe_b, pu_en, ext_en, ext_val,
  output logic [7:0] pin_in
);
  logic [7:0] tog = 8'h55;
  // A floating pad shows a changing pattern, so no stale level can pass.
  always @(posedge clk) tog <= ~tog;
  assign pin_in = (~oe_b & pin_out) | (oe_b & ext_en & ext_val)
    | (oe_b & ~ext_en & (pu_en | tog));
endmodule : pxb_pin_model
`default_nettype wire

// ===== tb/testbench.sv
// Directed register and pin tests for the port crossbar.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr = 1'b0, rmw = 1'b0, tx = 1'b1, sda = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, ext_en = 8'h00, ext_val = 8'h00;
  logic [2:0] cex = 3'h0;
  logic cmps = 1'b0;
  logic cmpa = 1'b0;
  wire logic [7:0] rdata, pin_in, pin_out, oe_b, pu_en;
  wire logic sda_in, scl_in, rx, t0, t1, capcomp_ext_clock_in;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  pxb_port_crossbar dut (.CLK(clk), .RST_B(rst_b), .SFR_WR(wr),
    .SFR_RD_RMW(rmw), .SFR_ADDR(addr), .SFR_WDATA(wdata),
    .SFR_RDATA(rdata), .PIN_IN(pin_in), .PIN_OUT(pin_out),
    .PIN_OE_B(oe_b), .PIN_PULLUP_EN(pu_en), .CEX_OUT(cex),
    .CMP_SYNC_OUT(cmps), .CMP_ASYNC_OUT(cmpa), .SDA_OUT(sda),
    .SCL_OUT(1'b1), .UART_TX(tx), .SDA_IN(sda_in), .SCL_IN(scl_in),
    .UART_RX(rx), .T0_IN(t0), .T1_IN(t1), .ECI_IN(capcomp_ext_clock_in));
  pxb_pin_model pads (.clk(clk), .pin_out(pin_out), .oe_b(oe_b),
    .pu_en(pu_en), .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
  task automatic chk(input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, e, input logic m);
    @(posedge clk);
    addr <= a;
    rmw <= m;
    #1;
    chk(rdata, e);
  endtask : rreg
  // Pin flops settle one step after the edge, so look just past it.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rreg(8'h80, 8'hFF, 1'b1);
    rreg(8'hE2, 8'h00, 1'b0);
    rreg(8'hF1, 8'hFF, 1'b0);
    rreg(8'hF3, 8'h00, 1'b0);
    rreg(pxb_pkg::ADDR_OUT_MODE, 8'h00, 1'b0);
    wreg(8'hF3, 8'hFF);
    rreg(8'hF3, 8'hC7, 1'b0);
    wreg(8'hF3, 8'h00);
    wreg(8'h00, 8'h55);
    rreg(8'h00, 8'h00, 1'b0);
    $display("test registers done");
    wreg(8'h80, 8'h5A);
    tick(3);
    rreg(8'h80, 8'hFF, 1'b0);
    rreg(8'h80, 8'h5A, 1'b1);
    $display("test latch done");
    @(posedge clk);
    ext_en <= 8'hFF;
    wreg(8'hF1, 8'h0F);
    tick(3);
    rreg(8'h80, 8'hF0, 1'b0);
    chk(pu_en, 8'h0F);
    wreg(8'hF1, 8'hFF);
    ext_en <= 8'h00;
    $display("test analog done");
    wreg(8'h80, 8'hFF);
    wreg(pxb_pkg::ADDR_OUT_MODE, 8'h10);
    wreg(8'hE2, 8'h03);
    wreg(8'hF3, 8'h40);
    tx <= 1'b0;
    tick(2);
    chk(pin_out & 8'h10, 8'h00);
    chk(oe_b & 8'h10, 8'h00);
    @(posedge clk);
    tx <= 1'b1;
    ext_en <= 8'h20;
    tick(3);
    chk(pin_out & 8'h10, 8'h10);
    chk(8'(rx), 8'h00);
    @(posedge clk);
    ext_en <= 8'h00;
    tick(3);
    chk(8'(rx), 8'h01);
    $display("test uart done");
    wreg(pxb_pkg::ADDR_SKIP, 8'h01);
    wreg(8'hE2, 8'h04);
    wreg(pxb_pkg::ADDR_OUT_MODE, 8'hFF);
    sda <= 1'b0;
    tick(2);
    chk(oe_b & 8'h07, 8'h04);
    @(posedge clk);
    sda <= 1'b1;
    tick(2);
    chk(oe_b & 8'h07, 8'h06);
    $display("test serial bus done");
    // Priority walk: sync comparator, async comparator, clock, three
    // compare outputs, counter input, timer 0; timer 1 finds no pin.
    wreg(pxb_pkg::ADDR_SKIP, 8'h00);
    wreg(8'h80, 8'hBF);
    wreg(pxb_pkg::ADDR_OUT_MODE, 8'h3F);
    ext_en <= 8'h80;
    cex <= 3'h5;
    cmps <= 1'b1;
    wreg(8'hE2, 8'hF8);
    wreg(8'hF3, 8'h47);
    tick(4);
    chk(pin_out, 8'hA9);
    chk(oe_b, 8'h80);
    chk(pu_en, 8'h80);
    chk(8'({t0, t1, capcomp_ext_clock_in}), 8'h02);
    ext_en <= 8'h00;
    $display("test priority done");
    wreg(pxb_pkg::ADDR_OUT_MODE, 8'h00);
    wreg(8'hF3, 8'hC0);
    tick(2);
    chk(pu_en, 8'h00);
    wreg(8'hF3, 8'h00);
    tick(2);
    chk(oe_b, 8'hFF);
    chk(8'({sda_in, scl_in, rx, t0, t1, capcomp_ext_clock_in}), 8'h3F);
    $display("test crossbar off done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
